//--- src/agc_pkg.sv
// package of constants and carriers for the automatic gain loop controller
`default_nettype none
package agc_pkg;
  // gain codes count half-dB steps relative to the lowest gain (-28 dB)
  localparam int GAIN_W = 8;
  localparam int STEP_HALF_DB = 1;
  localparam logic [7:0] GAIN_MIN_CODE = 8'h00;   // -28 dB
  localparam logic [7:0] GAIN_ZERO_DB = 8'h38;    // 0 dB
  localparam logic [7:0] GAIN_TOP_CODE = 8'h74;   // 30 dB
  // level inputs in dB steps, signed around the pivot at 10 dBV
  localparam int LVL_W = 8;
  localparam logic signed [7:0] PIVOT_DBV = 8'sh0A;
  localparam logic [7:0] NEAR_BAND = 8'h01;       // dead band around target, half-dB codes
  localparam int TMR_W = 20;
  // register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_GAIN = 4'h2;
  localparam logic [3:0] REG_LIM = 4'h3;
  localparam logic [3:0] REG_MAXG = 4'h4;
  localparam logic [3:0] REG_GATE = 4'h5;
  localparam logic [3:0] REG_ATK = 4'h6;
  localparam logic [3:0] REG_REL = 4'h7;
  localparam logic [3:0] REG_HOLD = 4'h8;
  localparam logic [3:0] REG_CUR = 4'h9;
  // control bit positions
  localparam int CTRL_AGC_EN = 0;
  localparam int CTRL_CMP_EN = 1;
  localparam int CTRL_HOLD_EN = 2;
  localparam int CTRL_SWSD = 5;
  localparam int STAT_FAULT = 3;
  localparam logic [1:0] RATIO_RESET = 2'h2;      // 4:1
  localparam int CTRL_RATIO_LSB = 3;
  typedef enum logic [1:0] {AGC_IDLE, AGC_RUN, AGC_SHUT} agc_mode_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } agc_bus_t;
endpackage
`default_nettype wire

//--- src/agc_ctrl.sv
// automatic gain loop controller with short-circuit fault handling
// ****************************************************************
// ****************************************************************
`default_nettype none
module agc_ctrl #(
  parameter int TMR_WIDTH = 20
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic shutdown_pin_n_i,
  input wire agc_pkg::agc_bus_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic signed [7:0] in_level_i,
  input wire logic short_det_i,
  output logic [7:0] gain_o,
  output logic gain_step_o,
  output logic low_duty_o,
  output logic fault_o
);
  import agc_pkg::*;

  typedef struct packed {
    agc_mode_t mode;
    logic agc_en;
    logic cmp_en;
    logic hold_en;
    logic sw_shutdown;
    logic [1:0] ratio;
    logic [7:0] fixed_gain;
    logic [7:0] max_gain;
    logic signed [7:0] limit;
    logic signed [7:0] gate;
    logic [TMR_WIDTH-1:0] atk_set;
    logic [TMR_WIDTH-1:0] rel_set;
    logic [TMR_WIDTH-1:0] hold_set;
    logic [TMR_WIDTH-1:0] atk_cnt;
    logic [TMR_WIDTH-1:0] rel_cnt;
    logic [TMR_WIDTH-1:0] hold_cnt;
    logic last_down;
    logic [7:0] gain;
    logic step;
    logic low_duty;
    logic fault;
    logic [15:0] rdata;
  } agc_state_t;

  agc_state_t st_r;
  agc_state_t st_nxt;

  // ************************************************
  // helpers
  // ************************************************
  // clamp the fixed gain code into the range allowed by the compression mode
  function automatic logic [7:0] fix_clamp(input logic [7:0] g, input logic cmp);
    logic [7:0] lo;
    lo = cmp ? GAIN_MIN_CODE : GAIN_ZERO_DB;
    if (g < lo)
      return lo;
    else if (g > GAIN_TOP_CODE)
      return GAIN_TOP_CODE;
    else
      return g;
  endfunction

  // counter decrement that stops at zero
  function automatic logic [TMR_WIDTH-1:0] tick(input logic [TMR_WIDTH-1:0] c);
    return (c == '0) ? c : c - 1'b1;
  endfunction

  // ************************************************
  // target gain from the compression curve
  // ************************************************
  // target gain in half-dB codes: pivot at 10 dBV, fixed gain at the pivot,
  // slope below pivot (1-1/ratio) dB of gain per dB of input fall
  logic signed [11:0] below_piv;
  logic signed [11:0] boost;
  logic signed [11:0] target;
  logic signed [11:0] out_lvl;
  logic signed [11:0] gain_db;
  logic [7:0] cap;
  always_comb
  begin
    below_piv = 12'(PIVOT_DBV) - 12'(in_level_i);
    if (below_piv < 0)
      below_piv = '0;
    // ratio 0..3 -> 1:1, 2:1, 4:1, 8:1; boost in half-dB = 2*drop*(1-1/r)
    case (st_r.ratio)
      2'h0: boost = '0;
      2'h1: boost = below_piv;
      2'h2: boost = below_piv + (below_piv >>> 1);
      default: boost = below_piv + (below_piv >>> 1) + (below_piv >>> 2);
    endcase
    if (!st_r.cmp_en)
      boost = '0;
    target = 12'(st_r.fixed_gain) + boost;
    cap = (st_r.max_gain > GAIN_TOP_CODE) ? GAIN_TOP_CODE : st_r.max_gain;
    if (target > 12'(cap))
      target = 12'(cap);
    // signed cast keeps the halving arithmetic for gains below 0 dB
    gain_db = $signed(12'(st_r.gain) - 12'(GAIN_ZERO_DB)) >>> 1;
    out_lvl = 12'(in_level_i) + gain_db;
  end

  // decision terms
  logic over_limit;
  logic want_down;
  logic want_up;
  logic gated;
  logic up_ready;
  always_comb
  begin
    over_limit = out_lvl > 12'(st_r.limit);
    gated = in_level_i < st_r.gate;
    // dead band of one code keeps a steady input from toggling the gain
    want_down = over_limit || (12'(st_r.gain) > target + 12'(NEAR_BAND));
    want_up = !over_limit && (12'(st_r.gain) + 12'(NEAR_BAND) < target);
    // hold replaces release only after a decrease, when enabled and longer
    if (st_r.last_down && st_r.hold_en && st_r.hold_set > st_r.rel_set)
      up_ready = st_r.hold_cnt == '0;
    else
      up_ready = st_r.rel_cnt == '0;
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.step = 1'b0;
    st_nxt.rdata = '0;
    st_nxt.atk_cnt = tick(st_r.atk_cnt);
    st_nxt.rel_cnt = tick(st_r.rel_cnt);
    st_nxt.hold_cnt = tick(st_r.hold_cnt);
    // register writes
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        REG_CTRL:
        begin
          st_nxt.agc_en = bus_i.wdata[CTRL_AGC_EN];
          st_nxt.cmp_en = bus_i.wdata[CTRL_CMP_EN];
          st_nxt.hold_en = bus_i.wdata[CTRL_HOLD_EN];
          st_nxt.sw_shutdown = bus_i.wdata[CTRL_SWSD];
          st_nxt.ratio = bus_i.wdata[CTRL_RATIO_LSB +: 2];
        end
        REG_GAIN: st_nxt.fixed_gain = bus_i.wdata[7:0];
        REG_LIM: st_nxt.limit = bus_i.wdata[7:0];
        REG_MAXG: st_nxt.max_gain = bus_i.wdata[7:0];
        REG_GATE: st_nxt.gate = bus_i.wdata[7:0];
        REG_ATK: st_nxt.atk_set = TMR_WIDTH'(bus_i.wdata);
        REG_REL: st_nxt.rel_set = TMR_WIDTH'(bus_i.wdata);
        REG_HOLD: st_nxt.hold_set = TMR_WIDTH'(bus_i.wdata);
        default: st_nxt.rdata = '0;
      endcase
    end
    // a write of one to the fault bit clears it; a new short wins
    if (bus_i.wr && bus_i.addr == REG_STAT && bus_i.wdata[STAT_FAULT])
      st_nxt.fault = 1'b0;
    st_nxt.fixed_gain = fix_clamp(st_nxt.fixed_gain, st_nxt.cmp_en);
    // gain loop
    case (st_r.mode)
      AGC_SHUT:
      begin
        st_nxt.gain = fix_clamp(st_r.fixed_gain, st_r.cmp_en);
        st_nxt.low_duty = 1'b0;
        st_nxt.mode = AGC_RUN;
      end
      AGC_RUN:
      begin
        if (!st_r.agc_en)
          st_nxt.gain = st_r.fixed_gain;
        else if (!gated && st_r.atk_cnt == '0)
        begin
          if (want_down && st_r.gain > GAIN_MIN_CODE)
          begin
            st_nxt.gain = st_r.gain - 8'(STEP_HALF_DB);
            st_nxt.step = 1'b1;
            st_nxt.last_down = 1'b1;
          end
          else if (want_up && up_ready && st_r.gain < cap)
          begin
            st_nxt.gain = st_r.gain + 8'(STEP_HALF_DB);
            st_nxt.step = 1'b1;
            st_nxt.last_down = 1'b0;
          end
        end
        if (st_nxt.step)
        begin
          st_nxt.atk_cnt = st_r.atk_set;
          st_nxt.rel_cnt = st_r.rel_set;
          st_nxt.hold_cnt = st_r.hold_set;
        end
      end
      default: st_nxt.mode = AGC_SHUT;
    endcase
    if (short_det_i)
    begin
      st_nxt.low_duty = 1'b1;
      st_nxt.fault = 1'b1;
    end
    // shutdown (pin or bit) resets the loop and releases low duty mode
    if (!shutdown_pin_n_i || st_nxt.sw_shutdown)
    begin
      st_nxt.mode = AGC_SHUT;
      st_nxt.low_duty = 1'b0;
      st_nxt.atk_cnt = '0;
      st_nxt.rel_cnt = '0;
      st_nxt.hold_cnt = '0;
      st_nxt.last_down = 1'b0;
    end
    // register reads, data next cycle
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        // read fields sit where the write decode takes them
        REG_CTRL: st_nxt.rdata = 16'({st_r.sw_shutdown, st_r.ratio,
                                     st_r.hold_en, st_r.cmp_en, st_r.agc_en});
        REG_STAT: st_nxt.rdata = 16'({st_r.low_duty, st_r.fault, 3'b000});
        REG_GAIN: st_nxt.rdata = 16'(st_r.fixed_gain);
        REG_LIM: st_nxt.rdata = 16'(st_r.limit);
        REG_MAXG: st_nxt.rdata = 16'(st_r.max_gain);
        REG_GATE: st_nxt.rdata = 16'(st_r.gate);
        REG_ATK: st_nxt.rdata = st_r.atk_set[15:0];
        REG_REL: st_nxt.rdata = st_r.rel_set[15:0];
        REG_HOLD: st_nxt.rdata = st_r.hold_set[15:0];
        REG_CUR: st_nxt.rdata = 16'(st_r.gain);
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
      st_r.mode <= AGC_SHUT;
      st_r.agc_en <= 1'b1;
      st_r.cmp_en <= 1'b1;
      st_r.ratio <= RATIO_RESET;
      st_r.fixed_gain <= GAIN_ZERO_DB;
      st_r.max_gain <= GAIN_TOP_CODE;
      st_r.limit <= PIVOT_DBV;
      st_r.gate <= 8'sh80;
      st_r.gain <= GAIN_ZERO_DB;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;
  assign gain_o = st_r.gain;
  assign gain_step_o = st_r.step;
  assign low_duty_o = st_r.low_duty;
  assign fault_o = st_r.fault;

  // ************************************************
  // checks
  // ************************************************
  AST_SHORT_LOWDUTY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    short_det_i && shutdown_pin_n_i && !st_nxt.sw_shutdown |=> low_duty_o)
    else $error("short did not force low duty");
  AST_LOWDUTY_HOLDS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    low_duty_o && shutdown_pin_n_i && !st_nxt.sw_shutdown |=> low_duty_o)
    else $error("low duty left without shutdown");
  AST_FAULT_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fault_o && !(bus_i.wr && bus_i.addr == REG_STAT) |=> fault_o)
    else $error("fault flag lost");
  AST_ONE_STEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gain_step_o |-> (gain_o == $past(gain_o) + 8'h01) || (gain_o == $past(gain_o) - 8'h01))
    else $error("gain step not one code");
  AST_GATE_FREEZE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gated && st_r.mode == AGC_RUN |=> !gain_step_o)
    else $error("gain moved below noise gate");
  AST_ATTACK_BLOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.atk_cnt != '0 |=> !gain_step_o)
    else $error("gain moved while attack running");
  AST_TIMER_RELOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gain_step_o |-> st_r.atk_cnt == $past(st_r.atk_set) && st_r.rel_cnt == $past(st_r.rel_set))
    else $error("timers not reloaded on step");
  AST_GAIN_CAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gain_step_o && !st_r.last_down |-> gain_o <= cap)
    else $error("gain above maximum");
  AST_FIXED_RANGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !st_r.cmp_en |-> st_r.fixed_gain >= GAIN_ZERO_DB)
    else $error("fixed gain below 0 dB without compression");

  // fault flag: set by a short, cleared by a write of one unless a short lands
  AST_FAULT_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    short_det_i |=> fault_o)
    else $error("short did not set fault flag");
  AST_FAULT_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_i.wr && bus_i.addr == REG_STAT && bus_i.wdata[STAT_FAULT] && !short_det_i |=> !fault_o)
    else $error("fault flag not cleared by write");

  // either shutdown source must drop low duty mode at the next edge
  AST_SHUT_RELEASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !shutdown_pin_n_i || st_nxt.sw_shutdown |=> !low_duty_o)
    else $error("shutdown did not release low duty");

  // gain source when the loop is parked or restarting
  AST_SHUT_LOADS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_SHUT |=> gain_o == $past(st_r.fixed_gain))
    else $error("gain not loaded from fixed gain");
  AST_FIXED_WHEN_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && !st_r.agc_en |=> gain_o == $past(st_r.fixed_gain))
    else $error("gain differs from fixed gain with loop off");
  AST_FIXED_TOP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.fixed_gain <= GAIN_TOP_CODE)
    else $error("fixed gain above top code");
  AST_GAIN_TOP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gain_o <= GAIN_TOP_CODE)
    else $error("gain above top code");

  // loop decisions; terms repeated so that a broken branch shows up
  AST_STEADY_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && st_r.agc_en && !want_down && !want_up |=> !gain_step_o)
    else $error("gain moved on a steady envelope");
  AST_LIMIT_DOWN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && st_r.agc_en && !gated && st_r.atk_cnt == '0 && over_limit
    && st_r.gain > GAIN_MIN_CODE |=> gain_step_o && gain_o == $past(gain_o) - 8'h01)
    else $error("gain not lowered above limiter");
  AST_RISE_UP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && st_r.agc_en && !gated && st_r.atk_cnt == '0 && !want_down
    && want_up && up_ready && st_r.gain < cap
    |=> gain_step_o && gain_o == $past(gain_o) + 8'h01)
    else $error("gain not raised below target");

  // increments wait out hold after a decrease when hold is enabled and longer, release otherwise
  AST_HOLD_WAIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && st_r.last_down && st_r.hold_en && st_r.hold_set > st_r.rel_set
    && st_r.hold_cnt != '0 |=> !(gain_step_o && gain_o > $past(gain_o)))
    else $error("gain rose before hold ran out");
  AST_RELEASE_WAIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.mode == AGC_RUN && !st_r.hold_en && st_r.rel_cnt != '0
    |=> !(gain_step_o && gain_o > $past(gain_o)))
    else $error("gain rose before release ran out");
  AST_DOWN_RESTART: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gain_step_o && gain_o < $past(gain_o) |-> st_r.last_down
    && st_r.hold_cnt == $past(st_r.hold_set))
    else $error("decrease did not restart hold timer");
endmodule
`default_nettype wire

//--- testbench/agc_env_model.sv
// envelope detector model standing in front of the gain loop's level input
`default_nettype none
module agc_env_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic signed [7:0] src_level_i,
  output logic signed [7:0] in_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock of detector lag; a real detector never tracks instantly
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      in_level_o <= 8'sh00;
    else
      in_level_o <= src_level_i;
  end
endmodule
`default_nettype wire

//--- testbench/agc_ctrl_test.sv
// self-checking bench for the automatic gain loop controller
`default_nettype none
module agc_ctrl_test import agc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic shutdown_pin_n_i = 1'b1;
  logic short_det_i = 1'b0;
  agc_bus_t bus_i = '0;
  logic signed [7:0] src_level = 8'sh0A;
  logic signed [7:0] in_level;
  logic [15:0] rdata_o;
  logic [7:0] gain_o;
  logic gain_step_o, low_duty_o, fault_o;
  int num_errors = 0;
  int checks = 0;
  logic [15:0] rd_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] gain_q = 8'h38;
  int since = 0, n_up = 0, n_down = 0, atk = 0, rel = 0, hold = 0;
  logic last_down = 1'b0;
  logic hold_en = 1'b0;
  logic [7:0] max_g = 8'h74;
  logic [31:0] rnd = 32'h00011B66;
  logic signed [7:0] lvl_base = 8'sh0A;
  logic [7:0] lvl_mask = 8'h00;

  initial forever #50 clk_i = ~clk_i;

  agc_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .shutdown_pin_n_i(shutdown_pin_n_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .in_level_i(in_level), .short_det_i(short_det_i),
    .gain_o(gain_o), .gain_step_o(gain_step_o), .low_duty_o(low_duty_o), .fault_o(fault_o));
  agc_env_model i_env (.clk_i(clk_i), .nrst_i(nrst_i), .src_level_i(src_level),
    .in_level_o(in_level));

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  // expected read data is noted before the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  // random jitter on the source keeps the detector honest
  task automatic run(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      rnd = xs(rnd);
      src_level <= lvl_base + $signed(rnd[7:0] & lvl_mask);
    end
  endtask
  task automatic wait_gain(input logic [7:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && gain_o !== exp; i++)
      run(1);
    chk(gain_o, exp);
    if (i == lim)
      report_and_stop();
    // let the watcher's step counts settle before anyone reads them
    run(1);
  endtask

  // ****************
  // watcher: read-back queue and step spacing
  // ****************
  always @(posedge clk_i)
  begin
    if (rd_seen)
      chk(rdata_o, rd_q.pop_front());
    rd_seen <= bus_i.rd;
    gain_q <= gain_o;
    since <= since + 1;
    if (gain_step_o === 1'b1)
    begin
      since <= 1;
      chk(gain_o > gain_q ? gain_o - gain_q : gain_q - gain_o, 16'h0001);
      chk(gain_o <= max_g, 1'b1);
      if (gain_o < gain_q)
      begin
        chk(since > atk, 1'b1);
        n_down <= n_down + 1;
      end
      else
      begin
        chk(since > ((last_down && hold_en && hold > rel) ? hold : rel), 1'b1);
        n_up <= n_up + 1;
      end
      last_down <= gain_o < gain_q;
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(REG_CTRL, 16'h0013);
    rd(REG_MAXG, 16'h0074);
    rd(REG_LIM, 16'h000A);
    rd(4'hF, 16'h0000);
    run(100);
    chk(n_up + n_down, 0);
    $display("test reset done");
    // timers loaded, hold longer than release so it governs the first rise
    wr(REG_GAIN, 16'h0038);
    wr(REG_ATK, 16'h0014);
    wr(REG_REL, 16'h001E);
    wr(REG_HOLD, 16'h003C);
    wr(REG_MAXG, 16'h0048);
    {atk, rel, hold, max_g, hold_en} = {32'd20, 32'd30, 32'd60, 8'h48, 1'b1};
    wr(REG_CTRL, 16'h0017);
    {lvl_base, lvl_mask} = {8'sh28, 8'h1F};
    wait_gain(8'h00, 2000);
    chk(n_down, 56);
    {lvl_base, lvl_mask} = {-8'sh14, 8'h00};
    wait_gain(8'h47, 3000);
    run(200);
    chk(gain_o, 8'h47);
    chk(n_up, 71);
    $display("test loop done");
    wr(REG_GATE, 16'h0050);
    {lvl_base, lvl_mask} = {8'sh1E, 8'h0F};
    run(300);
    chk(n_down, 56);
    hold_en = 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      wr(REG_CTRL, 16'h0003 | (r << 3));
      rd(REG_CTRL, 16'h0003 | (r << 3));
    end
    $display("test gate done");
    wr(REG_MAXG, 16'h0074);
    max_g = 8'h74;
    wr(REG_CTRL, 16'h0012);
    wr(REG_GAIN, 16'h0010);
    run(3);
    chk(gain_o, 8'h10);
    wr(REG_CTRL, 16'h0010);
    run(3);
    chk(gain_o, 8'h38);
    wr(REG_GAIN, 16'h007F);
    run(3);
    chk(gain_o, 8'h74);
    rd(REG_CUR, 16'h0074);
    $display("test fixed done");
    for (int k = 0; k < 2; k++)
    begin
      short_det_i <= 1'b1;
      run(1);
      short_det_i <= 1'b0;
      run(1);
      chk({low_duty_o, fault_o}, 2'b11);
      rd(REG_STAT, 16'h0018);
      wr(REG_STAT, 16'h0008);
      rd(REG_STAT, 16'h0010);
      if (k == 0)
        wr(REG_CTRL, 16'h0030);
      else
        shutdown_pin_n_i <= 1'b0;
      run(2);
      chk(low_duty_o, 1'b0);
      wr(REG_CTRL, 16'h0010);
      shutdown_pin_n_i <= 1'b1;
      run(3);
    end
    $display("test short done");
    run(5);
    report_and_stop();
  end
endmodule
`default_nettype wire
